// [ast_baud_gen.sv]
`timescale 1ns/1ps
`include "ast_params.svh"

module ast_baud_gen (
	input  wire logic   clk,
	input  wire logic   rst,
	ast_tick_if.gen     tk
);
	logic [7:0] count_q;
	logic       tick_q;

	// Period is divisor+1 clocks; restarts while idle so a frame aligns
	always_ff @(posedge clk) begin // see RULE4
		if (rst || !tk.run) begin
			count_q <= `AST_DIVISOR_RESET;
			tick_q  <= 1'b0;
		end else if (count_q == tk.divisor) begin
			count_q <= `AST_DIVISOR_RESET;
			tick_q  <= 1'b1;
		end else begin
			count_q <= count_q + 8'h01;
			tick_q  <= 1'b0;
		end
	end

	assign tk.tick = tick_q;

endmodule : ast_baud_gen

// [ast_params.svh]
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

// Idle and frame levels on the serial line
`define AST_MARK            1'b1
`define AST_SPACE           1'b0
// Data bits per character
`define AST_DATA_BITS_8     4'h8
`define AST_DATA_BITS_9     4'h9
// Reset values of the control inputs' derived state
`define AST_DIVISOR_RESET   8'h00
// Cycles from a buffer write until the empty flag is valid
`define AST_FLAG_SETTLE     2'h2

`endif

// [ast_pkg.sv]
package ast_pkg;

	typedef enum logic [2:0] {
		AST_IDLE  = 3'b001,
		AST_SHIFT = 3'b010,
		AST_STOP  = 3'b100
	} ast_state_t;

endpackage : ast_pkg

// [ast_rx_model.sv]
`timescale 1ns/1ps
module ast_rx_model (
	input  wire logic       clk,
	input  wire logic       line,
	input  wire logic       nine,
	input  wire logic [7:0] div,
	output logic      [8:0] data,
	output int              got,
	output int              bad
);
	logic [8:0] d;
	initial begin
		got = 0;
		bad = 0;
		data = 9'h000;
		forever begin
			@(posedge clk);
			if (line === 1'b0) begin
				// Sample mid-bit so edge jitter never matters
				repeat (div / 2) @(posedge clk);
				d = 9'h000;
				for (int i = 0; i < (nine ? 9 : 8); i++) begin
					repeat (div + 1) @(posedge clk);
					d[i] = line;
				end
				repeat (div + 1) @(posedge clk);
				if (line !== 1'b1) bad++;
				data = d;
				got++;
			end
		end
	end
endmodule : ast_rx_model

// [ast_tick_if.sv]
`timescale 1ns/1ps

interface ast_tick_if;
	logic       run;
	logic [7:0] divisor;
	logic       tick;

	modport ctrl (
		output run,
		output divisor,
		input  tick
	);
	modport gen (
		input  run,
		input  divisor,
		output tick
	);
endinterface : ast_tick_if

// [ast_transmitter.sv]
// Functional notes
// RULE1: Line rests at mark whenever no character is being sent.
// RULE2: Frame is start space, eight or nine data bits, mark stop, NRZ.
// RULE3: Every bit, start and stop included, lasts exactly one baud period.
// RULE4: Bit timing comes from an 8-bit divider on the system clock.
// RULE5: Data bits go out least significant bit first.
// RULE6: Transmit and receive share format and baud setting, otherwise independent.
// RULE7: No hardware parity; software may place parity in ninth bit.
// RULE8: Transmitter runs only with transmit enable, port enable, async mode.
// RULE9: Port enable forces the serial output pin to drive.
// RULE10: Port enable forces serial input pin to input, level still readable.
// RULE11: Setting transmit enable sets the buffer empty flag.
// RULE12: Buffer write starts sending; moves to idle shifter at once.
// RULE13: Buffered character waits for stop bit, then loads within one cycle.
// RULE14: Frame starts shifting immediately after load into shifter.
// RULE15: Shift register is not software accessible; loaded only from buffer.
// RULE16: Empty flag set when enabled and buffer empty; valid two cycles after write.
// RULE17: Shifter empty status clears on load, sets after all bits out.
// RULE18: Software writes ninth bit before the low eight bits.
// RULE19: Exactly one stop bit; back-to-back characters leave no idle gap.
`timescale 1ns/1ps
`include "ast_params.svh"

module ast_transmitter (
	input  wire logic       REF_CLK,
	input  wire logic       RST,
	input  wire logic       PORT_ENABLE,
	input  wire logic       TRANSMIT_ENABLE,
	input  wire logic       SYNC_MODE,
	input  wire logic       NINE_BIT_TX_SELECT,
	input  wire logic       TX_NINTH_BIT,
	input  wire logic [7:0] BAUD_DIVISOR,
	input  wire logic [7:0] TX_WRITE_DATA,
	input  wire logic       TX_WRITE,
	input  wire logic       PIN_DIRECTION_OUT,
	input  wire logic       PIN_LATCH_OUT,
	input  wire logic       PIN_DIRECTION_IN,
	input  wire logic       PIN_LATCH_IN,
	input  wire logic       SERIAL_IN_PIN_I,
	output logic            SERIAL_OUT_PIN_O,
	output logic            SERIAL_OUT_PIN_OE,
	output logic            SERIAL_IN_PIN_O,
	output logic            SERIAL_IN_PIN_OE,
	output logic            SERIAL_IN_LEVEL,
	output logic            TX_BUFFER_EMPTY_FLAG,
	output logic            SHIFTER_EMPTY_STATUS
);
	ast_tick_if tk ();

	ast_pkg::ast_state_t state_q;
	logic [8:0]          tx_holding_buffer_q;
	logic                buf_full_q;
	logic [9:0]          tx_shift_register_q;
	logic [3:0]          bits_left_q;
	logic                line_q;
	logic                flag_q;
	logic                shifter_empty_status_q;
	logic                in_s1_q;
	logic                in_s2_q;
	logic                in_s3_q;
	logic                in_lvl_q;
	logic                active;
	logic                load;
	logic                frame_end;
	logic                shifting;
	logic                flag_d;
	logic                shifter_empty_status_d;

	// Divider is the transmitter's own, not shared with a receiver; it starts on the
	// load edge, else the first bit of a frame is one clock longer
	assign tk.run     = shifting; // see RULE6
	assign tk.divisor = BAUD_DIVISOR;

	ast_baud_gen u_baud (
		.clk (REF_CLK),
		.rst (RST),
		.tk  (tk.gen)
	);

	assign active = TRANSMIT_ENABLE && PORT_ENABLE && !SYNC_MODE; // see RULE8
	assign frame_end = (state_q == ast_pkg::AST_STOP) && tk.tick;
	// Load at once when idle, or on the stop bit's final tick
	assign load = active && buf_full_q &&
		((state_q == ast_pkg::AST_IDLE) || frame_end); // see RULE12 RULE13
	// Busy from the load edge until the stop bit's last tick
	assign shifting = load ||
		((state_q != ast_pkg::AST_IDLE) && !frame_end); // see RULE3

	// Holding buffer; ninth bit sampled with the low byte
	always_ff @(posedge REF_CLK) begin
		if (RST || !TRANSMIT_ENABLE) begin
			buf_full_q          <= 1'b0;
			tx_holding_buffer_q <= 9'h000;
		end else if (TX_WRITE) begin
			// A write racing a load overwrites the freed slot
			buf_full_q          <= 1'b1;
			tx_holding_buffer_q <= {TX_NINTH_BIT, TX_WRITE_DATA}; // see RULE18
		end else if (load) begin
			buf_full_q <= 1'b0;
		end
	end

	// Frame sequencer; the shifter is fed only from the buffer
	always_ff @(posedge REF_CLK) begin // see RULE15
		if (RST || !active) begin
			state_q             <= ast_pkg::AST_IDLE;
			tx_shift_register_q <= 10'h3FF;
			bits_left_q         <= 4'h0;
		end else if (load) begin
			// Start bit at bit 0, then data LSB first
			state_q             <= ast_pkg::AST_SHIFT; // see RULE14
			tx_shift_register_q <= {tx_holding_buffer_q, `AST_SPACE};
			bits_left_q         <= NINE_BIT_TX_SELECT ? `AST_DATA_BITS_9
				: `AST_DATA_BITS_8; // see RULE2 RULE7
		end else if (tk.tick) begin
			case (state_q)
				ast_pkg::AST_SHIFT: begin
					tx_shift_register_q <= {`AST_MARK,
						tx_shift_register_q[9:1]}; // see RULE5
					if (bits_left_q == 4'h0) begin
						state_q <= ast_pkg::AST_STOP;
					end else begin
						bits_left_q <= bits_left_q - 4'h1;
					end
				end
				ast_pkg::AST_STOP: begin
					state_q <= ast_pkg::AST_IDLE; // see RULE19
				end
				default: begin
					state_q <= ast_pkg::AST_IDLE;
				end
			endcase
		end
	end

	// Stop bit is the mark forced in the stop state; one baud per bit
	always_ff @(posedge REF_CLK) begin // see RULE3
		if (RST) begin
			line_q <= `AST_MARK;
		end else if (state_q == ast_pkg::AST_IDLE) begin
			line_q <= `AST_MARK; // see RULE1
		end else if (state_q == ast_pkg::AST_STOP) begin
			line_q <= `AST_MARK; // see RULE2
		end else begin
			line_q <= tx_shift_register_q[0];
		end
	end

	// Next values of the two status bits
	always_comb begin
		flag_d = 1'b0;
		shifter_empty_status_d = 1'b1;
		if (TRANSMIT_ENABLE) begin
			// A load frees the slot unless a write refills it
			flag_d = !TX_WRITE && (!buf_full_q || load); // see RULE16
		end
		if (shifting) begin
			shifter_empty_status_d = 1'b0; // see RULE17
		end
	end

	// Registered flag lags one edge, so it is valid on the second cycle
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d; // see RULE11
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			shifter_empty_status_q <= 1'b1;
		end else begin
			shifter_empty_status_q <= shifter_empty_status_d;
		end
	end

	// Three-stage synchroniser for the input pin level
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			in_s1_q  <= `AST_MARK;
			in_s2_q  <= `AST_MARK;
			in_s3_q  <= `AST_MARK;
			in_lvl_q <= `AST_MARK;
		end else begin
			in_s1_q <= SERIAL_IN_PIN_I;
			in_s2_q <= in_s1_q;
			in_s3_q <= in_s2_q;
			if (in_s2_q == in_s3_q) begin
				in_lvl_q <= in_s3_q; // see RULE10
			end
		end
	end

	// Pin muxing; port latch is cut off while the port owns the pins
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			SERIAL_OUT_PIN_O  <= `AST_MARK;
			SERIAL_OUT_PIN_OE <= 1'b0;
		end else begin
			SERIAL_OUT_PIN_OE <= PORT_ENABLE || PIN_DIRECTION_OUT; // see RULE9
			SERIAL_OUT_PIN_O  <= PORT_ENABLE ? line_q : PIN_LATCH_OUT;
		end
	end

	// Input pin is forced to input while the port is on; level always sampled
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			SERIAL_IN_PIN_O   <= 1'b0;
			SERIAL_IN_PIN_OE  <= 1'b0;
		end else begin
			SERIAL_IN_PIN_OE  <= !PORT_ENABLE && PIN_DIRECTION_IN; // see RULE10
			SERIAL_IN_PIN_O   <= PORT_ENABLE ? 1'b0 : PIN_LATCH_IN;
		end
	end

	assign SERIAL_IN_LEVEL      = in_lvl_q;
	assign TX_BUFFER_EMPTY_FLAG = flag_q;
	assign SHIFTER_EMPTY_STATUS = shifter_empty_status_q;

endmodule : ast_transmitter

// [ast_transmitter_asserts.sv]
`timescale 1ns/1ps
module ast_transmitter_asserts (
	input wire logic       REF_CLK,
	input wire logic       RST,
	input wire logic       PORT_ENABLE,
	input wire logic       TRANSMIT_ENABLE,
	input wire logic       SYNC_MODE,
	input wire logic       TX_WRITE,
	input wire logic       SERIAL_OUT_PIN_O,
	input wire logic       SERIAL_OUT_PIN_OE,
	input wire logic       TX_BUFFER_EMPTY_FLAG,
	input wire logic       SHIFTER_EMPTY_STATUS,
	input wire logic [7:0] BAUD_DIVISOR
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	logic        act, o_q;
	logic [15:0] run_q;
	assign act = PORT_ENABLE && TRANSMIT_ENABLE && !SYNC_MODE;
	// Run length of the pin level; 16 bits so ten zero bits (start plus nine data) never wrap
	always_ff @(posedge REF_CLK) begin
		o_q   <= RST | SERIAL_OUT_PIN_O;
		run_q <= (RST || SERIAL_OUT_PIN_O != o_q) ? 16'h0001 : run_q + 16'h0001;
	end
	sequence idle_wr;
		act && TX_WRITE && SHIFTER_EMPTY_STATUS && TX_BUFFER_EMPTY_FLAG &&
			!$past(TX_WRITE) && !$past(TX_WRITE, 2);
	endsequence
	a_idle_mark:
		assert property ((SHIFTER_EMPTY_STATUS && PORT_ENABLE)[*3] |->
			SERIAL_OUT_PIN_O) else $error("line not at mark while idle");
	a_pin_driven:
		assert property (PORT_ENABLE[*2] |-> SERIAL_OUT_PIN_OE)
			else $error("out pin not driven");
	a_flag_off:
		assert property (!TRANSMIT_ENABLE[*2] |-> !TX_BUFFER_EMPTY_FLAG)
			else $error("flag set while disabled");
	a_flag_on:
		assert property ($rose(TRANSMIT_ENABLE) && !TX_WRITE ##1 !TX_WRITE
			|-> ##[0:1] TX_BUFFER_EMPTY_FLAG) else $error("flag not set");
	a_flag_busy:
		assert property (act && TX_WRITE && !SHIFTER_EMPTY_STATUS &&
			!SERIAL_OUT_PIN_O && BAUD_DIVISOR > 8'h02 |-> ##2
			!TX_BUFFER_EMPTY_FLAG) else $error("flag set with char waiting");
	a_start_bit:
		assert property (idle_wr |-> ##[3:5] !SERIAL_OUT_PIN_O)
			else $error("no start bit after write");
	a_status_load:
		assert property (idle_wr |-> ##[1:3] !SHIFTER_EMPTY_STATUS)
			else $error("status not cleared on load");
	a_bit_width:
		assert property (SERIAL_OUT_PIN_O && !o_q && act |->
			run_q % ({8'h00, BAUD_DIVISOR} + 16'h0001) == 16'h0000)
			else $error("bit width wrong");
	c_idle_wr: cover property (idle_wr);
	c_flag: cover property ($rose(TX_BUFFER_EMPTY_FLAG));
	c_rise: cover property (SERIAL_OUT_PIN_O && !o_q && act);
endmodule : ast_transmitter_asserts

bind ast_transmitter ast_transmitter_asserts u_chk (
	.REF_CLK              (REF_CLK),
	.RST                  (RST),
	.PORT_ENABLE          (PORT_ENABLE),
	.TRANSMIT_ENABLE      (TRANSMIT_ENABLE),
	.SYNC_MODE            (SYNC_MODE),
	.TX_WRITE             (TX_WRITE),
	.SERIAL_OUT_PIN_O     (SERIAL_OUT_PIN_O),
	.SERIAL_OUT_PIN_OE    (SERIAL_OUT_PIN_OE),
	.TX_BUFFER_EMPTY_FLAG (TX_BUFFER_EMPTY_FLAG),
	.SHIFTER_EMPTY_STATUS (SHIFTER_EMPTY_STATUS),
	.BAUD_DIVISOR         (BAUD_DIVISOR)
);

// [tb_async_serial_transmitter.sv]
`timescale 1ns/1ps
module tb_async_serial_transmitter;
	logic REF_CLK = 0, RST = 1, PORT_ENABLE = 0, TRANSMIT_ENABLE = 0;
	logic SYNC_MODE = 0, NINE_BIT_TX_SELECT = 0, TX_NINTH_BIT = 0;
	logic TX_WRITE = 0, PIN_DIRECTION_OUT = 1, PIN_LATCH_OUT = 1;
	logic PIN_DIRECTION_IN = 1, PIN_LATCH_IN = 1, SERIAL_IN_PIN_I = 0;
	logic [7:0] BAUD_DIVISOR = 8'h03, TX_WRITE_DATA = 8'h00;
	logic SERIAL_OUT_PIN_O, SERIAL_OUT_PIN_OE, SERIAL_IN_PIN_O;
	logic SERIAL_IN_PIN_OE, SERIAL_IN_LEVEL, TX_BUFFER_EMPTY_FLAG;
	logic SHIFTER_EMPTY_STATUS;
	logic [8:0] rx_data;
	int rx_got, rx_bad, errors = 0, comparisons = 0, cyc = 0;
	wire logic line = SERIAL_OUT_PIN_OE ? SERIAL_OUT_PIN_O : 1'b1;
	ast_transmitter u_dut (
		.REF_CLK              (REF_CLK),
		.RST                  (RST),
		.PORT_ENABLE          (PORT_ENABLE),
		.TRANSMIT_ENABLE      (TRANSMIT_ENABLE),
		.SYNC_MODE            (SYNC_MODE),
		.NINE_BIT_TX_SELECT   (NINE_BIT_TX_SELECT),
		.TX_NINTH_BIT         (TX_NINTH_BIT),
		.BAUD_DIVISOR         (BAUD_DIVISOR),
		.TX_WRITE_DATA        (TX_WRITE_DATA),
		.TX_WRITE             (TX_WRITE),
		.PIN_DIRECTION_OUT    (PIN_DIRECTION_OUT),
		.PIN_LATCH_OUT        (PIN_LATCH_OUT),
		.PIN_DIRECTION_IN     (PIN_DIRECTION_IN),
		.PIN_LATCH_IN         (PIN_LATCH_IN),
		.SERIAL_IN_PIN_I      (SERIAL_IN_PIN_I),
		.SERIAL_OUT_PIN_O     (SERIAL_OUT_PIN_O),
		.SERIAL_OUT_PIN_OE    (SERIAL_OUT_PIN_OE),
		.SERIAL_IN_PIN_O      (SERIAL_IN_PIN_O),
		.SERIAL_IN_PIN_OE     (SERIAL_IN_PIN_OE),
		.SERIAL_IN_LEVEL      (SERIAL_IN_LEVEL),
		.TX_BUFFER_EMPTY_FLAG (TX_BUFFER_EMPTY_FLAG),
		.SHIFTER_EMPTY_STATUS (SHIFTER_EMPTY_STATUS)
	);
	ast_rx_model u_rx (.clk(REF_CLK), .line(line), .nine(NINE_BIT_TX_SELECT),
		.div(BAUD_DIVISOR), .data(rx_data), .got(rx_got), .bad(rx_bad));
	always #10 REF_CLK = ~REF_CLK;
	task automatic ck(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask : ck
	task automatic chk(input string what, input logic [8:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] d, input logic b8);
		@(posedge REF_CLK);
		TX_WRITE_DATA <= d;
		TX_NINTH_BIT <= b8;
		TX_WRITE <= 1'b1;
		@(posedge REF_CLK);
		TX_WRITE <= 1'b0;
	endtask : wr
	task automatic rx(input int n, input logic [8:0] exp);
		for (int i = 0; i < 3000 && rx_got < n; i++) @(posedge REF_CLK);
		chk("rx", rx_data, exp);
	endtask : rx
	task automatic t_pins;
		ck(6);
		chk("oe", SERIAL_OUT_PIN_OE, 9'h001);
		chk("o", SERIAL_OUT_PIN_O, 9'h001);
		chk("in_oe", SERIAL_IN_PIN_OE, 9'h001);
		chk("in_o", SERIAL_IN_PIN_O, 9'h001);
		chk("lvl", SERIAL_IN_LEVEL, 9'h000);
		// Latch low and direction off: only the port can keep the mark
		PORT_ENABLE <= 1'b1;
		PIN_DIRECTION_OUT <= 1'b0;
		PIN_LATCH_OUT <= 1'b0;
		SERIAL_IN_PIN_I <= 1'b1;
		ck(6);
		chk("oe", SERIAL_OUT_PIN_OE, 9'h001);
		chk("o", SERIAL_OUT_PIN_O, 9'h001);
		chk("in_oe", SERIAL_IN_PIN_OE, 9'h000);
		chk("lvl", SERIAL_IN_LEVEL, 9'h001);
		$display("t_pins done");
	endtask : t_pins
	task automatic t_flag;
		chk("flag", TX_BUFFER_EMPTY_FLAG, 9'h000);
		TRANSMIT_ENABLE <= 1'b1;
		ck(3);
		chk("flag", TX_BUFFER_EMPTY_FLAG, 9'h001);
		$display("t_flag done");
	endtask : t_flag
	task automatic t_b2b;
		// Low bits zero so the second write lands in a space bit
		wr(8'h3C, 1'b0);
		ck(4);
		wr(8'hA5, 1'b0);
		ck(2);
		chk("flag", TX_BUFFER_EMPTY_FLAG, 9'h000);
		rx(1, 9'h03C);
		ck(3);
		chk("gap", SERIAL_OUT_PIN_O, 9'h000);
		rx(2, 9'h0A5);
		ck(8);
		chk("empty", SHIFTER_EMPTY_STATUS, 9'h001);
		$display("t_b2b done");
	endtask : t_b2b
	task automatic t_nine;
		NINE_BIT_TX_SELECT <= 1'b1;
		wr(8'h5A, 1'b1);
		rx(3, 9'h15A);
		wr(8'hFF, 1'b0);
		rx(4, 9'h0FF);
		NINE_BIT_TX_SELECT <= 1'b0;
		$display("t_nine done");
	endtask : t_nine
	task automatic t_gate;
		SYNC_MODE <= 1'b1;
		wr(8'hC3, 1'b0);
		ck(60);
		chk("got", rx_got[8:0], 9'h004);
		SYNC_MODE <= 1'b0;
		rx(5, 9'h0C3);
		chk("bad", rx_bad[8:0], 9'h000);
		$display("t_gate done");
	endtask : t_gate
	task automatic complete_run;
		$display("checks %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			complete_run;
		end
	end
	initial begin
		ck(8);
		RST <= 1'b0;
		t_pins;
		t_flag;
		t_b2b;
		t_nine;
		t_gate;
		complete_run;
	end
endmodule : tb_async_serial_transmitter
